// ### inc/fsag_consts.vh
// Constants for the flash security access guard
`ifndef FSAG_CONSTS_VH
`define FSAG_CONSTS_VH
// ----------------------------------------
// Register indices, reset values and write mask
// ----------------------------------------
`define FSAG_CTRL_IDX 10'h0b7
`define FSAG_LIMIT_IDX 10'h0b8
`define FSAG_STAT_IDX 10'h0b9
`define FSAG_CTRL_RST 8'h80
`define FSAG_CTRL_WMASK 8'hc1
`define FSAG_LIMIT_RST 8'h00
// ----------------------------------------
// Control and status fields
// ----------------------------------------
`define FSAG_OSE_BIT 7
`define FSAG_RAE_BIT 6
`define FSAG_PME_BIT 0
`define FSAG_ST_RDLK_LSB 0
`define FSAG_ST_WELK_LSB 8
`define FSAG_ST_REF_LSB 16
`define FSAG_ST_REF_MSB 18
// ----------------------------------------
// Flash map
// ----------------------------------------
`define FSAG_SEC_PAGE 7'h7e
`define FSAG_RSV_PAGE 7'h7f
`define FSAG_RDLK_ADDR 16'hfdff
`define FSAG_WELK_ADDR 16'hfdfe
`define FSAG_LOCK_ERASED 8'hff
`define FSAG_ZERO_BYTE 8'h00
`define FSAG_LIMIT_LOW 8'h00
// ----------------------------------------
// Operation codes and states
// ----------------------------------------
`define FSAG_JOP_READ 2'h0
`define FSAG_JOP_WRITE 2'h1
`define FSAG_JOP_ERASE 2'h2
`define FSAG_JOP_FULL 2'h3
`define FSAG_OWN_CRD 2'h0
`define FSAG_OWN_CWR 2'h1
`define FSAG_OWN_JTG 2'h2
`endif

// ### hw/fsag_top.v
// Flash security access guard: lock bytes, read limit, flash control register
// How it works
// - Lock bits stay readable and clearable whatever lock covers their page.
// - Only a JTAG erase can set lock bits back to one.
// - JTAG erase addressing a security byte erases all but the reserved area.
// - JTAG erase of another byte in the security page erases that page only.
// - Read limit splits memory: upper is at or above, lower below.
// - Upper code reading a lower address with the code read gets zero.
// - Lower code reads both partitions freely, except the reserved area, which reads as zero.
// - Limit address is limit byte in upper byte, zero low byte.
// - Limit byte resets to zero so all memory is readable.
// - JTAG reads, writes and erases of locked blocks are blocked.
// - JTAG may always read and write the security bytes.
// - Unlocked security page erase resets lock bytes, unlocking everything.
// - Locked security page refuses direct erase; full erase still clears.
// - Reserved area is never read, written or erased.
// - Lock bytes never restrict firmware accesses.
// - Firmware may read and write but never erase the security page.
// - Upper firmware cannot read, write or erase below the limit.
// - Instruction fetches below the limit are always executed.
// - Control bit 7 enables the read one-shot, reset value one.
// - Control bit 6 makes flash read on every cycle.
// - Control bit 0 gates all firmware writes and erases.
// - Each lock bit covers one 8 KB block, zero means locked.
// - JTAG read of a read-locked location returns undefined data; this design returns zero.
`timescale 1ns/10ps
`include "fsag_consts.vh"
module fsag_top (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	input wire [7:0] boot_rdlk,
	input wire [7:0] boot_welk,
	input wire cpu_rd_req,
	input wire cpu_rd_fetch,
	input wire [15:0] cpu_rd_addr,
	input wire [15:0] cpu_pc,
	output wire cpu_rd_ack,
	output reg cpu_rd_valid,
	output reg [7:0] cpu_rd_data,
	input wire cpu_wr_req,
	input wire cpu_wr_erase,
	input wire [15:0] cpu_wr_addr,
	input wire [7:0] cpu_wr_data,
	output wire cpu_wr_ack,
	output reg cpu_wr_done,
	output reg cpu_wr_err,
	input wire jtag_req,
	input wire [1:0] jtag_op,
	input wire [15:0] jtag_addr,
	input wire [7:0] jtag_wdata,
	output wire jtag_ack,
	output reg jtag_done,
	output reg jtag_err,
	output reg [7:0] jtag_rdata,
	output reg fl_rd,
	output reg fl_wr,
	output reg fl_page_erase,
	output reg fl_mass_erase,
	output reg [15:0] fl_addr,
	output reg [7:0] fl_wdata,
	input wire fl_done,
	input wire [7:0] fl_rdata,
	output wire fl_oneshot_en,
	output wire fl_read_always
);
	localparam ST_IDLE = 2'd0;
	localparam ST_BUSY = 2'd1;
	localparam ST_LOAD = 2'd2;

	// ----------------------------------------
	// Address helpers
	// ----------------------------------------
	function is_rsv;
		input [15:0] a;
		begin
			is_rsv = (a[15:9] == `FSAG_RSV_PAGE);
		end
	endfunction

	function is_sec_page;
		input [15:0] a;
		begin
			is_sec_page = (a[15:9] == `FSAG_SEC_PAGE);
		end
	endfunction

	function is_sec_byte;
		input [15:0] a;
		begin
			is_sec_byte = (a == `FSAG_RDLK_ADDR) || (a == `FSAG_WELK_ADDR);
		end
	endfunction

	// Below the limit means lower partition
	function is_low;
		input [15:0] a;
		input [7:0] lim;
		begin
			is_low = (a < {lim, `FSAG_LIMIT_LOW});
		end
	endfunction

	// One lock bit per 8 KB block, zero locks it
	function blk_open;
		input [15:0] a;
		input [7:0] lk;
		begin
			blk_open = lk[a[15:13]];
		end
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg [7:0] ctrl_r;
	reg [7:0] limit_r;
	reg [7:0] rdlk_r;
	reg [7:0] welk_r;
	reg [2:0] ref_r;
	reg [1:0] state_r;
	reg [1:0] own_r;
	reg zero_r;
	reg [2:0] ref_set;

	wire apb_wr = psel && penable && pwrite;
	wire [9:0] idx = paddr[11:2];
	wire hit = (idx == `FSAG_CTRL_IDX) || (idx == `FSAG_LIMIT_IDX) ||
		(idx == `FSAG_STAT_IDX);

	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign fl_oneshot_en = ctrl_r[`FSAG_OSE_BIT];
	assign fl_read_always = ctrl_r[`FSAG_RAE_BIT];

	// ----------------------------------------
	// Grant: code reads first, then firmware writes, then JTAG
	// ----------------------------------------
	wire idle = (state_r == ST_IDLE);
	assign cpu_rd_ack = idle && cpu_rd_req;
	assign cpu_wr_ack = idle && !cpu_rd_req && cpu_wr_req;
	assign jtag_ack = idle && !cpu_rd_req && !cpu_wr_req && jtag_req;

	// Partition checks use the executing address of this very cycle
	wire pc_up = !is_low(cpu_pc, limit_r);
	wire crd_lowblk = pc_up && is_low(cpu_rd_addr, limit_r) && !cpu_rd_fetch;
	wire crd_ok = !is_rsv(cpu_rd_addr) && !crd_lowblk;
	wire cwr_ok = ctrl_r[`FSAG_PME_BIT] &&
		!is_rsv(cpu_wr_addr) &&
		!(cpu_wr_erase && is_sec_page(cpu_wr_addr)) &&
		!(pc_up && is_low(cpu_wr_addr, limit_r));

	// JTAG permission and erase scope
	wire sec_open = blk_open(`FSAG_WELK_ADDR, welk_r);
	wire j_sec = is_sec_byte(jtag_addr);
	wire j_rsv = is_rsv(jtag_addr);
	reg j_ok;
	reg j_mass;
	always @* begin
		j_ok = 1'b0;
		j_mass = 1'b0;
		case (jtag_op)
			`FSAG_JOP_READ: begin
				j_ok = !j_rsv && (j_sec || blk_open(jtag_addr, rdlk_r));
			end
			`FSAG_JOP_WRITE: begin
				j_ok = !j_rsv && (j_sec || blk_open(jtag_addr, welk_r));
			end
			`FSAG_JOP_ERASE: begin
				if (j_sec) begin
					j_ok = 1'b1;
					j_mass = 1'b1;
				end else if (is_sec_page(jtag_addr)) begin
					j_ok = sec_open;
				end else begin
					j_ok = !j_rsv && blk_open(jtag_addr, welk_r);
				end
			end
			`FSAG_JOP_FULL: begin
				j_ok = 1'b1;
				j_mass = 1'b1;
			end
			default: begin
				j_ok = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Sequencer and flash command issue
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_LOAD;
			own_r <= `FSAG_OWN_CRD;
			zero_r <= 1'b0;
			fl_rd <= 1'b0;
			fl_wr <= 1'b0;
			fl_page_erase <= 1'b0;
			fl_mass_erase <= 1'b0;
			fl_addr <= 16'h0000;
			fl_wdata <= 8'h00;
			cpu_rd_valid <= 1'b0;
			cpu_rd_data <= 8'h00;
			cpu_wr_done <= 1'b0;
			cpu_wr_err <= 1'b0;
			jtag_done <= 1'b0;
			jtag_err <= 1'b0;
			jtag_rdata <= 8'h00;
			ref_set <= 3'b000;
		end else begin
			fl_rd <= 1'b0;
			fl_wr <= 1'b0;
			fl_page_erase <= 1'b0;
			fl_mass_erase <= 1'b0;
			cpu_rd_valid <= 1'b0;
			cpu_wr_done <= 1'b0;
			jtag_done <= 1'b0;
			ref_set <= 3'b000;
			case (state_r)
				ST_LOAD: begin
					state_r <= ST_IDLE;
				end
				ST_IDLE: begin
					if (cpu_rd_ack) begin
						// Refused code reads skip the array and answer zero at once
						own_r <= `FSAG_OWN_CRD;
						zero_r <= !crd_ok;
						ref_set[0] <= !crd_ok;
						fl_rd <= crd_ok;
						fl_addr <= cpu_rd_addr;
						if (crd_ok) begin
							state_r <= ST_BUSY;
						end else begin
							cpu_rd_valid <= 1'b1;
							cpu_rd_data <= `FSAG_ZERO_BYTE;
						end
					end else if (cpu_wr_ack) begin
						own_r <= `FSAG_OWN_CWR;
						fl_addr <= cpu_wr_addr;
						fl_wdata <= cpu_wr_data;
						fl_wr <= cwr_ok && !cpu_wr_erase;
						fl_page_erase <= cwr_ok && cpu_wr_erase;
						if (cwr_ok) begin
							state_r <= ST_BUSY;
						end else begin
							cpu_wr_done <= 1'b1;
							cpu_wr_err <= 1'b1;
							ref_set[1] <= 1'b1;
						end
					end else if (jtag_ack) begin
						own_r <= `FSAG_OWN_JTG;
						fl_addr <= jtag_addr;
						fl_wdata <= jtag_wdata;
						fl_rd <= j_ok && (jtag_op == `FSAG_JOP_READ);
						fl_wr <= j_ok && (jtag_op == `FSAG_JOP_WRITE);
						fl_page_erase <= j_ok && (jtag_op == `FSAG_JOP_ERASE) && !j_mass;
						fl_mass_erase <= j_ok && j_mass;
						if (j_ok) begin
							state_r <= ST_BUSY;
						end else begin
							// Locked data is undefined; zero is what we give
							jtag_done <= 1'b1;
							jtag_err <= 1'b1;
							jtag_rdata <= `FSAG_ZERO_BYTE;
							ref_set[2] <= 1'b1;
						end
					end
				end
				ST_BUSY: begin
					if (fl_done) begin
						state_r <= ST_IDLE;
						case (own_r)
							`FSAG_OWN_CRD: begin
								cpu_rd_valid <= 1'b1;
								cpu_rd_data <= zero_r ? `FSAG_ZERO_BYTE : fl_rdata;
							end
							`FSAG_OWN_CWR: begin
								cpu_wr_done <= 1'b1;
								cpu_wr_err <= 1'b0;
							end
							default: begin
								jtag_done <= 1'b1;
								jtag_err <= 1'b0;
								jtag_rdata <= fl_rdata;
							end
						endcase
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Lock byte shadows
	// ----------------------------------------
	// Shadows follow flash: writes only clear bits, only JTAG erases set them
	wire wr_go = fl_wr && (state_r == ST_BUSY);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdlk_r <= `FSAG_LOCK_ERASED;
			welk_r <= `FSAG_LOCK_ERASED;
		end else if (state_r == ST_LOAD) begin
			// Stored bytes are captured once after reset release
			rdlk_r <= boot_rdlk;
			welk_r <= boot_welk;
		end else if (own_r == `FSAG_OWN_JTG && (fl_mass_erase ||
			(fl_page_erase && is_sec_page(fl_addr)))) begin
			rdlk_r <= `FSAG_LOCK_ERASED;
			welk_r <= `FSAG_LOCK_ERASED;
		end else if (wr_go && fl_addr == `FSAG_RDLK_ADDR) begin
			rdlk_r <= rdlk_r & fl_wdata;
		end else if (wr_go && fl_addr == `FSAG_WELK_ADDR) begin
			welk_r <= welk_r & fl_wdata;
		end
	end

	// ----------------------------------------
	// APB registers
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `FSAG_CTRL_RST;
			limit_r <= `FSAG_LIMIT_RST;
			ref_r <= 3'b000;
		end else begin
			if (apb_wr && idx == `FSAG_CTRL_IDX) begin
				ctrl_r <= pwdata[7:0] & `FSAG_CTRL_WMASK;
			end
			if (apb_wr && idx == `FSAG_LIMIT_IDX) begin
				limit_r <= pwdata[7:0];
			end
			// Set wins over a same-cycle write-one clear
			if (apb_wr && idx == `FSAG_STAT_IDX) begin
				ref_r <= (ref_r & ~pwdata[`FSAG_ST_REF_MSB:`FSAG_ST_REF_LSB]) | ref_set;
			end else begin
				ref_r <= ref_r | ref_set;
			end
		end
	end

	reg [31:0] rdata_nxt;
	always @* begin
		rdata_nxt = 32'h0000_0000;
		case (idx)
			`FSAG_CTRL_IDX: rdata_nxt[7:0] = ctrl_r;
			`FSAG_LIMIT_IDX: rdata_nxt[7:0] = limit_r;
			`FSAG_STAT_IDX: begin
				rdata_nxt[`FSAG_ST_RDLK_LSB+7:`FSAG_ST_RDLK_LSB] = rdlk_r;
				rdata_nxt[`FSAG_ST_WELK_LSB+7:`FSAG_ST_WELK_LSB] = welk_r;
				rdata_nxt[`FSAG_ST_REF_MSB:`FSAG_ST_REF_LSB] = ref_r;
			end
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end

	// Read data is caught at the setup edge so it stands through the access phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= rdata_nxt;
		end
	end
endmodule // fsag_top

// ### dv/fsag_props.sv
// Port checker for the flash security access guard
`timescale 1ns/10ps
module fsag_props (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire cpu_rd_ack,
	input wire cpu_rd_fetch,
	input wire [15:0] cpu_rd_addr,
	input wire [15:0] cpu_pc,
	input wire cpu_rd_valid,
	input wire [7:0] cpu_rd_data,
	input wire fl_rd,
	input wire cpu_wr_ack,
	input wire cpu_wr_erase,
	input wire [15:0] cpu_wr_addr,
	input wire cpu_wr_done,
	input wire cpu_wr_err,
	input wire fl_wr,
	input wire fl_page_erase,
	input wire jtag_ack,
	input wire [1:0] jtag_op,
	input wire [15:0] jtag_addr,
	input wire jtag_done,
	input wire jtag_err,
	input wire fl_mass_erase,
	input wire fl_oneshot_en,
	input wire fl_read_always
);
	logic [7:0] ctl_r;
	logic [7:0] lim_r;
	wire apw = psel && penable && pwrite;
	wire [15:0] lim16 = {lim_r, 8'h00};
	// Shadow of control and limit, so the partition is judged as the design sees it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_r <= 8'h80;
			lim_r <= 8'h00;
		end else if (apw && paddr == 12'h2dc) begin
			ctl_r <= pwdata[7:0] & 8'hc1;
		end else if (apw && paddr == 12'h2e0) begin
			lim_r <= pwdata[7:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_ctl_wr;
		apw && paddr == 12'h2dc;
	endsequence
	sequence s_cwr_ref;
		##1 cpu_wr_done && cpu_wr_err && !fl_wr && !fl_page_erase;
	endsequence
	a_ctl_pins: assert property (
		s_ctl_wr |=> fl_oneshot_en == $past(pwdata[7]) && fl_read_always == $past(pwdata[6]))
		else $error("ctrl pins");
	a_upper_zero: assert property (
		cpu_rd_ack && !cpu_rd_fetch && cpu_pc >= lim16 && cpu_rd_addr < lim16
		|=> cpu_rd_valid && cpu_rd_data == 8'h00 && !fl_rd) else $error("upper read");
	a_lower_free: assert property (
		cpu_rd_ack && cpu_pc < lim16 && cpu_rd_addr < 16'hfe00 |=> fl_rd) else $error("lower");
	a_wr_gate: assert property (
		cpu_wr_ack && !ctl_r[0] |-> s_cwr_ref) else $error("wr gate");
	a_sec_no_erase: assert property (
		cpu_wr_ack && cpu_wr_erase && cpu_wr_addr[15:9] == 7'h7e |-> s_cwr_ref)
		else $error("sec erase");
	a_upper_no_wr: assert property (
		cpu_wr_ack && cpu_pc >= lim16 && cpu_wr_addr < lim16 |-> s_cwr_ref) else $error("upper wr");
	a_sec_mass: assert property (
		jtag_ack && jtag_op == 2'h2 && jtag_addr[15:1] == 15'h7eff |=> fl_mass_erase)
		else $error("mass");
	a_rsv_block: assert property (
		jtag_ack && jtag_op != 2'h3 && jtag_addr[15:9] == 7'h7f |=> jtag_done && jtag_err)
		else $error("reserved");
endmodule // fsag_props

// ### dv/fsag_flash_model.sv
// Flash array model answering command pulses
`timescale 1ns/10ps
module fsag_flash_model (
	input wire pclk,
	input wire presetn,
	input wire slow,
	input wire fl_rd,
	input wire fl_wr,
	input wire fl_page_erase,
	input wire fl_mass_erase,
	input wire [15:0] fl_addr,
	output logic fl_done,
	output logic [7:0] fl_rdata
);
	logic [3:0] cnt_r;
	logic rd_r;
	// Data toggles outside fl_done so a stale byte never passes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 4'h0;
			rd_r <= 1'b0;
			fl_done <= 1'b0;
			fl_rdata <= 8'h00;
		end else begin
			fl_done <= 1'b0;
			fl_rdata <= ~fl_rdata;
			if (fl_rd | fl_wr | fl_page_erase | fl_mass_erase) begin
				cnt_r <= slow ? 4'h9 : 4'h1;
				rd_r <= fl_rd;
			end else if (cnt_r != 4'h0) begin
				cnt_r <= cnt_r - 4'h1;
				fl_done <= cnt_r == 4'h1;
				if (cnt_r == 4'h1 && rd_r)
					fl_rdata <= fl_addr[7:0] ^ fl_addr[15:8];
			end
		end
	end
endmodule // fsag_flash_model

// ### dv/fsag_top_tb.sv
// Self-checking bench for the flash security access guard
`timescale 1ns/10ps
module fsag_top_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0] boot_rdlk, boot_welk, cpu_rd_data, cpu_wr_data, jtag_wdata, jtag_rdata;
	logic [7:0] fl_wdata, fl_rdata;
	logic cpu_rd_req, cpu_rd_fetch, cpu_rd_ack, cpu_rd_valid, cpu_wr_req, cpu_wr_erase;
	logic cpu_wr_ack, cpu_wr_done, cpu_wr_err, jtag_req, jtag_ack, jtag_done, jtag_err;
	logic fl_rd, fl_wr, fl_page_erase, fl_mass_erase, fl_done, fl_oneshot_en, fl_read_always;
	logic [1:0] jtag_op;
	logic [15:0] cpu_rd_addr, cpu_pc, cpu_wr_addr, jtag_addr, fl_addr;
	int fails, tests_run;
	fsag_top i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.boot_rdlk(boot_rdlk), .boot_welk(boot_welk), .cpu_rd_req(cpu_rd_req),
		.cpu_rd_fetch(cpu_rd_fetch), .cpu_rd_addr(cpu_rd_addr), .cpu_pc(cpu_pc),
		.cpu_rd_ack(cpu_rd_ack), .cpu_rd_valid(cpu_rd_valid), .cpu_rd_data(cpu_rd_data),
		.cpu_wr_req(cpu_wr_req), .cpu_wr_erase(cpu_wr_erase), .cpu_wr_addr(cpu_wr_addr),
		.cpu_wr_data(cpu_wr_data), .cpu_wr_ack(cpu_wr_ack), .cpu_wr_done(cpu_wr_done),
		.cpu_wr_err(cpu_wr_err), .jtag_req(jtag_req), .jtag_op(jtag_op),
		.jtag_addr(jtag_addr), .jtag_wdata(jtag_wdata), .jtag_ack(jtag_ack),
		.jtag_done(jtag_done), .jtag_err(jtag_err), .jtag_rdata(jtag_rdata),
		.fl_rd(fl_rd), .fl_wr(fl_wr), .fl_page_erase(fl_page_erase),
		.fl_mass_erase(fl_mass_erase), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
		.fl_done(fl_done), .fl_rdata(fl_rdata), .fl_oneshot_en(fl_oneshot_en),
		.fl_read_always(fl_read_always)
	);
	fsag_flash_model i_fl (
		.pclk(pclk), .presetn(presetn), .slow(slow), .fl_rd(fl_rd), .fl_wr(fl_wr),
		.fl_page_erase(fl_page_erase), .fl_mass_erase(fl_mass_erase), .fl_addr(fl_addr),
		.fl_done(fl_done), .fl_rdata(fl_rdata)
	);
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] er,
		input logic ee);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		if (!w)
			chk(prdata, er);
		chk(pslverr, ee);
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle cycle so the next call never rewrites psel in this time step
		@(posedge pclk);
	endtask
	task cr(input logic f, input logic [15:0] a, input logic [15:0] p, input logic [7:0] ed);
		cpu_rd_req <= 1'b1;
		cpu_rd_fetch <= f;
		cpu_rd_addr <= a;
		cpu_pc <= p;
		do @(posedge pclk); while (cpu_rd_ack !== 1'b1);
		cpu_rd_req <= 1'b0;
		do @(posedge pclk); while (cpu_rd_valid !== 1'b1);
		chk(cpu_rd_data, ed);
	endtask
	task cw(input logic e, input logic [15:0] a, input logic [7:0] d, input logic [15:0] p,
		input logic ee, input logic [2:0] ec);
		logic [2:0] cmd;
		cpu_wr_req <= 1'b1;
		cpu_wr_erase <= e;
		cpu_wr_addr <= a;
		cpu_wr_data <= d;
		cpu_pc <= p;
		do @(posedge pclk); while (cpu_wr_ack !== 1'b1);
		cpu_wr_req <= 1'b0;
		// Command pulses stand in the cycle right after the accepting edge
		@(posedge pclk);
		cmd = {fl_mass_erase, fl_page_erase, fl_rd | fl_wr};
		while (cpu_wr_done !== 1'b1) @(posedge pclk);
		chk(cpu_wr_err, ee);
		chk(cmd, ec);
		if (!e && !ee) chk({fl_addr, fl_wdata}, {a, d});
	endtask
	task jt(input logic [1:0] o, input logic [15:0] a, input logic [7:0] d, input logic ee,
		input logic [2:0] ec, input logic [7:0] ed);
		logic [2:0] cmd;
		jtag_req <= 1'b1;
		jtag_op <= o;
		jtag_addr <= a;
		jtag_wdata <= d;
		do @(posedge pclk); while (jtag_ack !== 1'b1);
		jtag_req <= 1'b0;
		@(posedge pclk);
		cmd = {fl_mass_erase, fl_page_erase, fl_rd | fl_wr};
		while (jtag_done !== 1'b1) @(posedge pclk);
		chk(jtag_err, ee);
		chk(cmd, ec);
		if (o == 2'h1 && !ee) chk({fl_addr, fl_wdata}, {a, d});
		if (o == 2'h0)
			chk(jtag_rdata, ed);
	endtask
	// --------
	// Scenarios
	// --------
	task t_regs;
		apb(0, 12'h2dc, 0, 32'h0000_0080, 0);
		apb(0, 12'h2e0, 0, 0, 0);
		apb(0, 12'h2e4, 0, 32'h0000_fdfe, 0);
		apb(1, 12'h2dc, 8'hc1, 0, 0);
		apb(0, 12'h2dc, 0, 32'h0000_00c1, 0);
		chk({fl_oneshot_en, fl_read_always}, 2'h3);
		apb(0, 12'h100, 0, 0, 1);
		apb(1, 12'h2dc, 8'h80, 0, 0);
		$display("t_regs done");
	endtask
	task t_limit;
		apb(1, 12'h2e0, 8'h10, 0, 0);
		cr(0, 16'h0fff, 16'h1000, 8'h00);
		cr(0, 16'h1000, 16'h1000, 8'h10);
		cr(0, 16'h0fff, 16'h0fff, 8'hf0);
		cr(1, 16'h0123, 16'h2000, 8'h22);
		cr(0, 16'hfe10, 16'h0100, 8'h00);
		$display("t_limit done");
	endtask
	task t_cpu_wr;
		cw(0, 16'h2000, 8'h55, 16'h0100, 1, 0);
		apb(1, 12'h2dc, 8'h01, 0, 0);
		cw(0, 16'h2000, 8'h55, 16'h0100, 0, 1);
		cw(1, 16'hfc10, 8'h00, 16'h0100, 1, 0);
		cw(0, 16'h0800, 8'h11, 16'h2000, 1, 0);
		cw(0, 16'hfdfe, 8'h7f, 16'h0100, 0, 1);
		apb(1, 12'h2e4, 32'h0007_0000, 0, 0);
		apb(0, 12'h2e4, 0, 32'h0000_7dfe, 0);
		$display("t_cpu_wr done");
	endtask
	task t_jtag;
		slow <= 1'b1;
		jt(0, 16'h0010, 0, 1, 0, 8'h00);
		jt(0, 16'h2010, 0, 0, 1, 8'h30);
		jt(0, 16'hfdff, 0, 0, 1, 8'h02);
		jt(1, 16'h2010, 8'h05, 1, 0, 0);
		jt(1, 16'hfdfe, 8'hfe, 0, 1, 0);
		jt(2, 16'hfc00, 0, 1, 0, 0);
		jt(0, 16'hfe00, 0, 1, 0, 8'h00);
		jt(2, 16'hfdff, 0, 0, 4, 0);
		jt(1, 16'hfdfe, 8'hfe, 0, 1, 0);
		jt(2, 16'hfc00, 0, 0, 2, 0);
		apb(0, 12'h2e4, 0, 32'h0004_ffff, 0);
		jt(3, 16'h1234, 0, 0, 4, 0);
		$display("t_jtag done");
	endtask
	// Mid-run reset: registers return to reset values, locks reload
	task t_reset;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk(fl_oneshot_en, 1'b1);
		apb(0, 12'h2dc, 0, 32'h0000_0080, 0);
		apb(0, 12'h2e0, 0, 0, 0);
		apb(0, 12'h2e4, 0, 32'h0000_fdfe, 0);
		$display("t_reset done");
	endtask
	task final_report;
		$display("tests_run=%0d fails=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, cpu_rd_req, cpu_wr_req, jtag_req, slow} = '0;
		{paddr, pwdata, cpu_rd_fetch, cpu_wr_erase, jtag_op} = '0;
		{cpu_rd_addr, cpu_pc, cpu_wr_addr, jtag_addr, cpu_wr_data, jtag_wdata} = '0;
		boot_rdlk = 8'hfe;
		boot_welk = 8'hfd;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		t_regs;
		t_limit;
		t_cpu_wr;
		t_jtag;
		t_reset;
		final_report;
	end
	// Whole run needs well under 2000 cycles
	initial begin
		#20000;
		fails++;
		final_report;
	end
endmodule // fsag_top_tb
bind fsag_top fsag_props u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .cpu_rd_ack(cpu_rd_ack), .cpu_rd_fetch(cpu_rd_fetch),
	.cpu_rd_addr(cpu_rd_addr), .cpu_pc(cpu_pc), .cpu_rd_valid(cpu_rd_valid),
	.cpu_rd_data(cpu_rd_data), .fl_rd(fl_rd), .cpu_wr_ack(cpu_wr_ack),
	.cpu_wr_erase(cpu_wr_erase), .cpu_wr_addr(cpu_wr_addr), .cpu_wr_done(cpu_wr_done),
	.cpu_wr_err(cpu_wr_err), .fl_wr(fl_wr), .fl_page_erase(fl_page_erase),
	.jtag_ack(jtag_ack), .jtag_op(jtag_op), .jtag_addr(jtag_addr), .jtag_done(jtag_done),
	.jtag_err(jtag_err), .fl_mass_erase(fl_mass_erase), .fl_oneshot_en(fl_oneshot_en),
	.fl_read_always(fl_read_always)
);
